// File: hw/pwm_pkg.sv
package pwm_pkg;
    // channel and datapath sizes
    localparam int NUM_CH = 6;
    localparam int CNT_W = 16;
    localparam int PSC_W = 12;
    localparam int SRC_W = 3;
    localparam int TRIG_N = 4;
    // counting types
    localparam logic [1:0] TYPE_UP = 2'h0;
    localparam logic [1:0] TYPE_DOWN = 2'h1;
    localparam logic [1:0] TYPE_UPDOWN = 2'h2;
    // waveform actions per event point
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    // clock source codes, timer n is SRC_TIMER0 + n
    localparam logic [2:0] SRC_SYS = 3'h0;
    localparam logic [2:0] SRC_TIMER0 = 3'h1;
    // adc trigger source codes
    localparam logic [1:0] ADC_OFF = 2'h0;
    localparam logic [1:0] ADC_ZERO = 2'h1;
    localparam logic [1:0] ADC_PERIOD = 2'h2;
    localparam logic [1:0] ADC_CMP = 2'h3;
    // values after reset
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [11:0] PSC_RST = 12'h000;
    localparam logic [15:0] BUF_RST = 16'h0000;
endpackage

// File: hw/cap_if.sv
`timescale 1ns/1ps
interface cap_if;
    logic [15:0] cnt;
    logic [5:0] enable;
    logic [5:0] rise_sel;
    logic [5:0] fall_sel;
    logic [5:0] rise_hit;
    logic [5:0] fall_hit;
    logic [5:0][15:0] rise_data;
    logic [5:0][15:0] fall_data;
    // pwm core side
    modport core (output cnt, enable, rise_sel, fall_sel, input rise_hit, fall_hit, rise_data, fall_data);
    // capture side
    modport cap (input cnt, enable, rise_sel, fall_sel, output rise_hit, fall_hit, rise_data, fall_data);
endinterface

// File: hw/capture_unit.sv
`timescale 1ns/1ps
module capture_unit (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [pwm_pkg::NUM_CH-1:0] pin_in,
    cap_if.cap bus
);
    import pwm_pkg::*;

    logic [NUM_CH-1:0] pin_prev;
    logic [NUM_CH-1:0] next_rise_hit;
    logic [NUM_CH-1:0] next_fall_hit;
    logic [NUM_CH-1:0][CNT_W-1:0] next_rise_data;
    logic [NUM_CH-1:0][CNT_W-1:0] next_fall_data;

    // edge detection and counter latch per channel
    always_comb begin
        next_rise_data = bus.rise_data;
        next_fall_data = bus.fall_data;
        next_rise_hit = pin_in & ~pin_prev & bus.enable & bus.rise_sel;
        next_fall_hit = ~pin_in & pin_prev & bus.enable & bus.fall_sel;
        for (int i = 0; i < NUM_CH; i++) begin
            if (next_rise_hit[i]) begin
                next_rise_data[i] = bus.cnt;
            end
            if (next_fall_hit[i]) begin
                next_fall_data[i] = bus.cnt;
            end
        end
    end

    // capture registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_prev <= '0;
            bus.rise_hit <= '0;
            bus.fall_hit <= '0;
            bus.rise_data <= '0;
            bus.fall_data <= '0;
        end else begin
            pin_prev <= pin_in;
            bus.rise_hit <= next_rise_hit;
            bus.fall_hit <= next_fall_hit;
            bus.rise_data <= next_rise_data;
            bus.fall_data <= next_fall_data;
        end
    end

    property p_rise_latch;
        @(posedge ref_clk) disable iff (!rstn)
        (bus.enable[1] && bus.rise_sel[1] && pin_in[1] && !pin_prev[1]) |=>
            (bus.rise_hit[1] && bus.rise_data[1] == $past(bus.cnt));
    endproperty
    a_rise_latch: assert property (p_rise_latch) else $error("rising capture missed");

    property p_fall_latch;
        @(posedge ref_clk) disable iff (!rstn)
        (bus.enable[1] && bus.fall_sel[1] && !pin_in[1] && pin_prev[1]) |=>
            (bus.fall_hit[1] && bus.fall_data[1] == $past(bus.cnt));
    endproperty
    a_fall_latch: assert property (p_fall_latch) else $error("falling capture missed");

    property p_no_spurious;
        @(posedge ref_clk) disable iff (!rstn)
        !bus.enable[2] |=> !bus.rise_hit[2] && !bus.fall_hit[2];
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("capture while disabled");

    c_rise_capture: cover property (@(posedge ref_clk) disable iff (!rstn) bus.rise_hit[1]);
endmodule // capture_unit

// File: hw/basic_pwm_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - six channels, each output or capture input
// - 12-bit prescaler, 16-bit counter and compares
// - one counter shared by all six channels
// - up, down and up-down counting types
// - zero, period, compare events shape waveforms
// - polarity, mask, tri-state enable per pin
// - capture counter on rising, falling or both
// - counter advances every prescale plus one
// - clock from system or four timer triggers
// - unit clock equal or double bus rate
// - event pulses for zero, period, compare
// - adc start on zero, period, compare
// - separate rising and falling capture events
// - capture may reload the shared counter
// - up type period lasts period plus one
// - up-down twice period, direction flag
// - buffers load when period completes
// - immediate load overrides other load modes
module basic_pwm_unit (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic unit_clk_double,
    input wire logic [pwm_pkg::SRC_W-1:0] clock_source_select,
    input wire logic [pwm_pkg::TRIG_N-1:0] timer_trig,
    input wire logic [pwm_pkg::PSC_W-1:0] prescale_value,
    input wire logic count_enable,
    input wire logic [1:0] count_type,
    input wire logic period_wr,
    input wire logic [pwm_pkg::CNT_W-1:0] period_data,
    input wire logic [pwm_pkg::NUM_CH-1:0] cmp_wr,
    input wire logic [pwm_pkg::CNT_W-1:0] cmp_data,
    input wire logic [pwm_pkg::NUM_CH-1:0] immediate_load_enable,
    input wire logic [pwm_pkg::NUM_CH-1:0] center_load_enable,
    input wire logic [pwm_pkg::NUM_CH-1:0][1:0] zero_action,
    input wire logic [pwm_pkg::NUM_CH-1:0][1:0] period_action,
    input wire logic [pwm_pkg::NUM_CH-1:0][1:0] cmp_up_action,
    input wire logic [pwm_pkg::NUM_CH-1:0][1:0] cmp_down_action,
    input wire logic [pwm_pkg::NUM_CH-1:0] polarity_invert,
    input wire logic [pwm_pkg::NUM_CH-1:0] mask_enable,
    input wire logic [pwm_pkg::NUM_CH-1:0] mask_data,
    input wire logic [pwm_pkg::NUM_CH-1:0] output_enable,
    input wire logic [pwm_pkg::NUM_CH-1:0] capture_enable,
    input wire logic [pwm_pkg::NUM_CH-1:0] capture_rise_sel,
    input wire logic [pwm_pkg::NUM_CH-1:0] capture_fall_sel,
    input wire logic [pwm_pkg::NUM_CH-1:0] capture_reload_enable,
    input wire logic [1:0] adc_trig_sel,
    input wire logic [2:0] adc_trig_chan,
    input wire logic [pwm_pkg::NUM_CH-1:0] pin_in,
    output logic [pwm_pkg::NUM_CH-1:0] pin_out,
    output logic [pwm_pkg::NUM_CH-1:0] pin_oe_n,
    output logic [pwm_pkg::CNT_W-1:0] cnt,
    output logic count_direction_flag,
    output logic [pwm_pkg::CNT_W-1:0] period_buf,
    output logic [pwm_pkg::NUM_CH-1:0][pwm_pkg::CNT_W-1:0] cmp_buf,
    output logic zero_event,
    output logic period_event,
    output logic [pwm_pkg::NUM_CH-1:0] cmp_event,
    output logic adc_start,
    output logic [pwm_pkg::NUM_CH-1:0] rise_capture_event,
    output logic [pwm_pkg::NUM_CH-1:0] fall_capture_event,
    output logic [pwm_pkg::NUM_CH-1:0][pwm_pkg::CNT_W-1:0] rise_capture_data,
    output logic [pwm_pkg::NUM_CH-1:0][pwm_pkg::CNT_W-1:0] fall_capture_data
);
    import pwm_pkg::*;

    // apply one event action to the current waveform level
    function automatic logic apply_act(input logic cur, input logic [1:0] act);
        case (act)
            ACT_LOW: apply_act = 1'b0;
            ACT_HIGH: apply_act = 1'b1;
            ACT_TOGGLE: apply_act = ~cur;
            default: apply_act = cur;
        endcase
    endfunction

    cap_if cif();

    logic half_phase;
    logic [TRIG_N-1:0] trig_prev;
    logic [PSC_W-1:0] psc_cnt;
    logic [CNT_W-1:0] period_shadow;
    logic [NUM_CH-1:0][CNT_W-1:0] cmp_shadow;
    logic [NUM_CH-1:0] wave;
    logic next_half_phase;
    logic [PSC_W-1:0] next_psc_cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_dir;
    logic [CNT_W-1:0] next_period_shadow;
    logic [CNT_W-1:0] next_period_buf;
    logic [NUM_CH-1:0][CNT_W-1:0] next_cmp_shadow;
    logic [NUM_CH-1:0][CNT_W-1:0] next_cmp_buf;
    logic [NUM_CH-1:0] next_wave;
    logic [NUM_CH-1:0] next_pin_out;
    logic next_adc_start;
    logic sys_tick;
    logic src_tick;
    logic cnt_tick;
    logic at_zero;
    logic at_period;
    logic zero_hit;
    logic period_hit;
    logic period_end;
    logic center_hit;
    logic reload_hit;
    logic [NUM_CH-1:0] cmp_hit;

    // system tick at full or half rate, then source select
    always_comb begin
        next_half_phase = ~half_phase;
        sys_tick = unit_clk_double | half_phase;
        case (clock_source_select)
            SRC_SYS: src_tick = sys_tick;
            SRC_TIMER0: src_tick = timer_trig[0] & ~trig_prev[0];
            SRC_TIMER0 + 3'h1: src_tick = timer_trig[1] & ~trig_prev[1];
            SRC_TIMER0 + 3'h2: src_tick = timer_trig[2] & ~trig_prev[2];
            SRC_TIMER0 + 3'h3: src_tick = timer_trig[3] & ~trig_prev[3];
            default: src_tick = 1'b0;
        endcase
    end

    // prescaler: one counter tick per prescale_value plus one source ticks
    always_comb begin
        cnt_tick = count_enable && src_tick && (psc_cnt >= prescale_value);
        next_psc_cnt = psc_cnt;
        if (!count_enable || cnt_tick) begin
            next_psc_cnt = PSC_RST;
        end else if (src_tick) begin
            next_psc_cnt = psc_cnt + 12'h001;
        end
    end

    // event decode against the active buffers
    always_comb begin
        at_zero = (cnt == CNT_RST);
        at_period = (cnt == period_buf);
        zero_hit = cnt_tick && at_zero;
        period_hit = cnt_tick && at_period;
        for (int i = 0; i < NUM_CH; i++) begin
            cmp_hit[i] = cnt_tick && (cnt == cmp_buf[i]);
        end
        case (count_type)
            TYPE_DOWN: period_end = zero_hit;
            TYPE_UPDOWN: period_end = zero_hit && !count_direction_flag;
            default: period_end = period_hit;
        endcase
        center_hit = period_hit && (count_type == TYPE_UPDOWN) && count_direction_flag;
        reload_hit = |((cif.rise_hit | cif.fall_hit) & capture_reload_enable);
    end

    // shared counter for all channels
    always_comb begin
        next_cnt = cnt;
        next_dir = count_direction_flag;
        if (!count_enable || reload_hit) begin
            next_dir = (count_type != TYPE_DOWN);
            next_cnt = (reload_hit && count_type == TYPE_DOWN) ? period_buf : CNT_RST;
        end else if (cnt_tick) begin
            case (count_type)
                TYPE_UP: begin
                    next_dir = 1'b1;
                    next_cnt = at_period ? CNT_RST : cnt + 16'h0001;
                end
                TYPE_DOWN: begin
                    next_dir = 1'b0;
                    next_cnt = at_zero ? period_buf : cnt - 16'h0001;
                end
                TYPE_UPDOWN: begin
                    if (count_direction_flag && at_period) begin
                        next_dir = 1'b0;
                        next_cnt = at_zero ? cnt : cnt - 16'h0001;
                    end else if (!count_direction_flag && at_zero) begin
                        next_dir = 1'b1;
                        next_cnt = at_period ? cnt : cnt + 16'h0001;
                    end else begin
                        next_cnt = count_direction_flag ? cnt + 16'h0001 : cnt - 16'h0001;
                    end
                end
                default: next_cnt = cnt;
            endcase
        end
    end

    // double buffering of period and compare values
    always_comb begin
        next_period_shadow = period_wr ? period_data : period_shadow;
        next_period_buf = period_buf;
        if (period_wr && immediate_load_enable[0]) begin
            next_period_buf = period_data;
        end else if (period_end && !immediate_load_enable[0]) begin
            next_period_buf = next_period_shadow;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            next_cmp_shadow[i] = cmp_wr[i] ? cmp_data : cmp_shadow[i];
            next_cmp_buf[i] = cmp_buf[i];
            if (immediate_load_enable[i]) begin
                if (cmp_wr[i]) begin
                    next_cmp_buf[i] = cmp_data;
                end
            end else if (center_load_enable[i] && count_type == TYPE_UPDOWN) begin
                if (center_hit) begin
                    next_cmp_buf[i] = next_cmp_shadow[i];
                end
            end else if (period_end) begin
                next_cmp_buf[i] = next_cmp_shadow[i];
            end
        end
    end

    // waveform generation and output control
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            next_wave[i] = wave[i];
            if (zero_hit) begin
                next_wave[i] = apply_act(next_wave[i], zero_action[i]);
            end
            if (cmp_hit[i]) begin
                next_wave[i] = apply_act(next_wave[i],
                    count_direction_flag ? cmp_up_action[i] : cmp_down_action[i]);
            end
            if (period_hit) begin
                next_wave[i] = apply_act(next_wave[i], period_action[i]);
            end
            next_pin_out[i] = mask_enable[i] ? mask_data[i] : (next_wave[i] ^ polarity_invert[i]);
        end
    end

    // adc start trigger select
    always_comb begin
        case (adc_trig_sel)
            ADC_ZERO: next_adc_start = zero_hit;
            ADC_PERIOD: next_adc_start = period_hit;
            ADC_CMP: next_adc_start = (adc_trig_chan < 3'h6) && cmp_hit[adc_trig_chan];
            default: next_adc_start = 1'b0;
        endcase
    end

    // state registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            half_phase <= 1'b0;
            trig_prev <= '0;
            psc_cnt <= PSC_RST;
            cnt <= CNT_RST;
            count_direction_flag <= 1'b1;
            period_shadow <= BUF_RST;
            period_buf <= BUF_RST;
            cmp_shadow <= '0;
            cmp_buf <= '0;
            wave <= '0;
            pin_out <= '0;
            pin_oe_n <= '1;
            zero_event <= 1'b0;
            period_event <= 1'b0;
            cmp_event <= '0;
            adc_start <= 1'b0;
        end else begin
            half_phase <= next_half_phase;
            trig_prev <= timer_trig;
            psc_cnt <= next_psc_cnt;
            cnt <= next_cnt;
            count_direction_flag <= next_dir;
            period_shadow <= next_period_shadow;
            period_buf <= next_period_buf;
            cmp_shadow <= next_cmp_shadow;
            cmp_buf <= next_cmp_buf;
            wave <= next_wave;
            pin_out <= next_pin_out;
            pin_oe_n <= ~(output_enable & ~capture_enable);
            zero_event <= zero_hit;
            period_event <= period_hit;
            cmp_event <= cmp_hit;
            adc_start <= next_adc_start;
        end
    end

    // capture block hookup
    assign cif.cnt = cnt;
    assign cif.enable = capture_enable;
    assign cif.rise_sel = capture_rise_sel;
    assign cif.fall_sel = capture_fall_sel;
    assign rise_capture_event = cif.rise_hit;
    assign fall_capture_event = cif.fall_hit;
    assign rise_capture_data = cif.rise_data;
    assign fall_capture_data = cif.fall_data;

    capture_unit u_capture (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin_in(pin_in),
        .bus(cif.cap)
    );

    property p_up_wrap;
        @(posedge ref_clk) disable iff (!rstn)
        (cnt_tick && !reload_hit && count_type == TYPE_UP && cnt == period_buf) |=> cnt == CNT_RST;
    endproperty
    a_up_wrap: assert property (p_up_wrap) else $error("up counter did not restart");

    property p_down_reload;
        @(posedge ref_clk) disable iff (!rstn)
        (cnt_tick && !reload_hit && count_type == TYPE_DOWN && cnt == CNT_RST) |=> cnt == $past(period_buf);
    endproperty
    a_down_reload: assert property (p_down_reload) else $error("down counter did not reload");

    property p_updown_turn;
        @(posedge ref_clk) disable iff (!rstn)
        (cnt_tick && !reload_hit && count_type == TYPE_UPDOWN && count_direction_flag
            && cnt == period_buf && cnt != CNT_RST) |=> !count_direction_flag && cnt == $past(cnt) - 16'h0001;
    endproperty
    a_updown_turn: assert property (p_updown_turn) else $error("up-down turn wrong");

    property p_hold_between_ticks;
        @(posedge ref_clk) disable iff (!rstn)
        (count_enable && !cnt_tick && !reload_hit) |=> $stable(cnt);
    endproperty
    a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("counter moved off tick");

    property p_zero_event;
        @(posedge ref_clk) disable iff (!rstn)
        cnt_tick |=> zero_event == ($past(cnt) == CNT_RST);
    endproperty
    a_zero_event: assert property (p_zero_event) else $error("zero event missing");

    property p_immediate;
        @(posedge ref_clk) disable iff (!rstn)
        (period_wr && immediate_load_enable[0]) |=> period_buf == $past(period_data);
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate load failed");

    property p_deferred;
        @(posedge ref_clk) disable iff (!rstn)
        (!immediate_load_enable[0] && !period_end) |=> period_buf == $past(period_buf);
    endproperty
    a_deferred: assert property (p_deferred) else $error("period buffer changed mid period");

    property p_mask;
        @(posedge ref_clk) disable iff (!rstn)
        mask_enable[0] |=> pin_out[0] == $past(mask_data[0]);
    endproperty
    a_mask: assert property (p_mask) else $error("mask not applied");

    property p_capture_reload;
        @(posedge ref_clk) disable iff (!rstn)
        (|((cif.rise_hit | cif.fall_hit) & capture_reload_enable) && count_type != TYPE_DOWN) |=> cnt == CNT_RST;
    endproperty
    a_capture_reload: assert property (p_capture_reload) else $error("capture reload missed");

    property p_adc_zero;
        @(posedge ref_clk) disable iff (!rstn)
        (zero_hit && adc_trig_sel == ADC_ZERO) |=> adc_start;
    endproperty
    a_adc_zero: assert property (p_adc_zero) else $error("adc trigger missing");

    c_updown_period: cover property (@(posedge ref_clk) disable iff (!rstn)
        count_type == TYPE_UPDOWN && period_end);
    c_immediate_load: cover property (@(posedge ref_clk) disable iff (!rstn)
        period_wr && immediate_load_enable[0]);
    c_adc_cmp: cover property (@(posedge ref_clk) disable iff (!rstn)
        adc_start && adc_trig_sel == ADC_CMP);
endmodule // basic_pwm_unit

// File: tb/pin_model.sv
`timescale 1ns/1ps
module pin_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe_n,
    input wire logic [5:0] ext_drive,
    input wire logic [5:0] ext_level,
    output logic [5:0] pin_in,
    output logic [3:0] timer_trig
);
    logic [2:0] div;
    // pin level from the block, the outside driver, or a floating pattern; one timer pulse every 5 cycles
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_in <= 6'h00;
            div <= 3'h0;
            timer_trig <= 4'h0;
        end else begin
            for (int i = 0; i < 6; i++) begin
                pin_in[i] <= !pin_oe_n[i] ? pin_out[i] : ext_drive[i] ? ext_level[i] : ~pin_in[i];
            end
            div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
            timer_trig <= {3'h0, div == 3'h4};
        end
    end
endmodule // pin_model

// File: tb/basic_pwm_unit_tb.sv
`timescale 1ns/1ps
module basic_pwm_unit_tb;
    import pwm_pkg::*;
    logic ref_clk = 0, rstn = 0, unit_clk_double = 1, period_wr = 0, count_enable = 0;
    logic [2:0] clock_source_select = SRC_SYS, adc_trig_chan = 3'h0;
    logic [1:0] count_type = TYPE_UP, adc_trig_sel = ADC_ZERO;
    logic [11:0] prescale_value = 12'h000;
    logic [15:0] period_data = 16'h0000, cmp_data = 16'h0000, cnt, period_buf, last_cnt;
    logic [5:0] cmp_wr = '0, immediate_load_enable = 6'h3f, center_load_enable = '0, polarity_invert = '0;
    logic [5:0] mask_enable = '0, mask_data = '0, output_enable = '0, capture_enable = '0, ext_level = '0;
    logic [5:0] capture_rise_sel = 6'h3f, capture_fall_sel = 6'h3f, capture_reload_enable = 6'h02, ext_drive = 6'h02;
    logic [5:0][1:0] zero_action = '0, period_action = '0, cmp_up_action = '0, cmp_down_action = '0;
    logic [5:0] pin_in, pin_out, pin_oe_n, cmp_event, rise_capture_event, fall_capture_event;
    logic [3:0] timer_trig;
    logic [5:0][15:0] cmp_buf, rise_capture_data, fall_capture_data;
    logic count_direction_flag, zero_event, period_event, adc_start;
    int err_count = 0, total_checks = 0, n;
    always #10 ref_clk = ~ref_clk;
    basic_pwm_unit uut (.ref_clk, .rstn, .unit_clk_double, .clock_source_select, .timer_trig, .prescale_value,
        .count_enable, .count_type, .period_wr, .period_data, .cmp_wr, .cmp_data, .immediate_load_enable,
        .center_load_enable, .zero_action, .period_action, .cmp_up_action, .cmp_down_action, .polarity_invert,
        .mask_enable, .mask_data, .output_enable, .capture_enable, .capture_rise_sel, .capture_fall_sel,
        .capture_reload_enable, .adc_trig_sel, .adc_trig_chan, .pin_in, .pin_out, .pin_oe_n, .cnt,
        .count_direction_flag, .period_buf, .cmp_buf, .zero_event, .period_event, .cmp_event, .adc_start,
        .rise_capture_event, .fall_capture_event, .rise_capture_data, .fall_capture_data);
    pin_model pm (.ref_clk, .rstn, .pin_out, .pin_oe_n, .ext_drive, .ext_level, .pin_in, .timer_trig);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    function automatic logic ev(input int s);
        case (s)
            0: return zero_event;
            1: return period_event;
            2: return cmp_event[2];
            3: return rise_capture_event[1];
            default: return fall_capture_event[1];
        endcase
    endfunction
    // bounded wait for an event pulse, keeping the count value of the cycle before it
    task automatic wait_ev(input int s, output int k);
        k = 0;
        do begin
            last_cnt = cnt;
            @(posedge ref_clk);
            #1;
            k++;
            if (k > 300) begin
                err_count++;
                $display("MISMATCH event wait expected 1 seen 0");
                finish_test();
            end
        end while (ev(s) !== 1'b1);
    endtask
    task automatic gap(input int s, input logic [15:0] exp, input string what);
        wait_ev(s, n);
        wait_ev(s, n);
        check(what, 16'(n), exp);
    endtask
    // restart the counter with a new type and an immediately loaded period
    task automatic run(input logic [1:0] t, input logic [15:0] p);
        @(posedge ref_clk);
        count_enable <= 0;
        count_type <= t;
        period_wr <= 1;
        period_data <= p;
        @(posedge ref_clk);
        period_wr <= 0;
        count_enable <= 1;
    endtask
    task automatic t_count();
        run(TYPE_UP, 16'h0002);
        @(posedge ref_clk);
        cmp_wr <= 6'h04;
        cmp_data <= 16'h0001;
        @(posedge ref_clk);
        cmp_wr <= 6'h00;
        #1;
        check("cmp_buf", cmp_buf[2], 16'h0001);
        gap(1, 16'h0003, "up period");
        gap(2, 16'h0003, "compare gap");
        wait_ev(1, n);
        @(posedge ref_clk);
        #1;
        check("zero after period", 16'(zero_event), 16'h0001);
        check("adc start", 16'(adc_start), 16'h0001);
        @(posedge ref_clk);
        adc_trig_sel <= ADC_CMP;
        adc_trig_chan <= 3'h2;
        wait_ev(2, n);
        check("adc on compare", 16'(adc_start), 16'h0001);
        @(posedge ref_clk);
        adc_trig_sel <= ADC_ZERO;
        prescale_value <= 12'h003;
        gap(1, 16'h000c, "prescaled period");
        @(posedge ref_clk);
        prescale_value <= 12'h000;
        unit_clk_double <= 0;
        gap(1, 16'h0006, "half rate period");
        @(posedge ref_clk);
        unit_clk_double <= 1;
        clock_source_select <= SRC_TIMER0;
        gap(1, 16'h000f, "timer period");
        @(posedge ref_clk);
        clock_source_select <= SRC_SYS;
        run(TYPE_DOWN, 16'h0003);
        gap(0, 16'h0004, "down period");
        wait_ev(0, n);
        @(posedge ref_clk);
        #1;
        check("reload after zero", 16'(period_event), 16'h0001);
        run(TYPE_UPDOWN, 16'h0003);
        gap(0, 16'h0006, "up-down period");
        wait_ev(1, n);
        check("dir down", 16'(count_direction_flag), 16'h0000);
        wait_ev(0, n);
        check("dir up", 16'(count_direction_flag), 16'h0001);
        $display("test count done");
    endtask
    task automatic t_buffer();
        run(TYPE_UP, 16'h0005);
        wait_ev(1, n);
        @(posedge ref_clk);
        immediate_load_enable <= 6'h00;
        period_wr <= 1;
        period_data <= 16'h0009;
        @(posedge ref_clk);
        period_wr <= 0;
        #1;
        check("period held", period_buf, 16'h0005);
        wait_ev(1, n);
        check("period loaded", period_buf, 16'h0009);
        gap(1, 16'h000a, "new period");
        @(posedge ref_clk);
        immediate_load_enable <= 6'h3f;
        $display("test buffer done");
    endtask
    task automatic t_capture();
        run(TYPE_UP, 16'h0100);
        @(posedge ref_clk);
        capture_enable <= 6'h02;
        output_enable <= 6'h02;
        for (int k = 0; k < 2; k++) begin
            repeat (20) @(posedge ref_clk);
            ext_level <= {4'h0, k == 0, 1'b0};
            #1;
            wait_ev(3 + k, n);
            check("capture data", k == 0 ? rise_capture_data[1] : fall_capture_data[1], last_cnt);
            @(posedge ref_clk);
            #1;
            check("reload", cnt, 16'h0000);
        end
        check("capture oe_n", 16'(pin_oe_n[1]), 16'h0001);
        $display("test capture done");
    endtask
    task automatic t_output();
        @(posedge ref_clk);
        polarity_invert <= 6'h01;
        output_enable <= 6'h01;
        repeat (3) @(posedge ref_clk);
        #1;
        check("inverted pin", 16'(pin_out[0]), 16'h0001);
        check("driving oe_n", 16'(pin_oe_n[0]), 16'h0000);
        @(posedge ref_clk);
        mask_enable <= 6'h01;
        repeat (3) @(posedge ref_clk);
        #1;
        check("masked pin", 16'(pin_out[0]), 16'h0000);
        @(posedge ref_clk);
        mask_enable <= 6'h00;
        zero_action[0] <= ACT_HIGH;
        wait_ev(0, n);
        repeat (2) @(posedge ref_clk);
        #1;
        check("zero sets wave", 16'(pin_out[0]), 16'h0000);
        $display("test output done");
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1;
        #1;
        check("reset cnt", cnt, CNT_RST);
        check("reset oe_n", 16'(pin_oe_n), 16'h003f);
        check("reset dir", 16'(count_direction_flag), 16'h0001);
        $display("test reset done");
        t_count();
        t_buffer();
        t_capture();
        t_output();
        finish_test();
    end
endmodule // basic_pwm_unit_tb
